// ### hdl/phy_soft_strap_config_two.sv
`include "phy_strap_cfg.svh"

module phy_soft_strap_config_two
  import phy_strap_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [`ADDR_W-1:0] addr,
  input wire logic [`DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [`DATA_W-1:0] rdata,
  // from the first strap register
  input wire logic config_done,
  input wire logic fast_mdix_mode,
  input wire logic robust_mdix_mode,
  // link state
  input wire link_state_t link_in,
  // receive symbol checker
  input wire logic rx_sym_err,
  input wire logic rx_idle,
  // transmit nibbles from the mac side
  input wire logic tx_nib_stb,
  input wire logic tx_en_in,
  input wire logic tx_er_in,
  // results
  output logic strap_reset_pulse,
  output link_ctrl_t ctrl,
  output logic rx_err_out,
  output logic tx_en_out,
  output logic tx_er_out,
  output logic tx_odd_err
);

  // software copy and the latched working copy
  strap_two_t ssc_two_r;
  strap_two_t ssc_two_nxt;
  strap_two_t work_r;

  // latch sequencer
  strap_state_t state_r;
  strap_state_t state_nxt;
  logic [3:0] pulse_cnt_r;
  logic latched_r;

  // far-end link drop
  logic link_seen_r;
  logic [15:0] drop_cnt_r;
  logic drop_active_r;

  // duplex outcome and the control flops
  logic full_duplex_c;
  logic full_duplex_r;
  logic link_led_r;
  logic mii_isolate_r;
  logic tx_disable_r;
  logic fast_pd_r;
  logic rmii_rx_clk_sel_r;

  // read path
  logic [`DATA_W-1:0] rdata_nxt;

  // transmitter hold after a link loss, in clock cycles
  localparam logic [15:0] DROP_HOLD = 16'(`FAR_DROP_HOLD_CYC);

  // ----------------------------------------
  // helpers
  // ----------------------------------------

  // an access that hits the given register
  function automatic logic hit(input logic [`ADDR_W-1:0] a, input logic [`ADDR_W-1:0] target);
    hit = (a == target);
  endfunction : hit

  // established 100 Mb link
  function automatic logic link_100(input link_state_t s);
    link_100 = s.link_up && s.speed_100;
  endfunction : link_100

  // ----------------------------------------
  // register write path
  // ----------------------------------------

  // next value: software write, then hardware set of fast link-up
  always_comb begin
    ssc_two_nxt = ssc_two_r;
    if (wr && hit(addr, `SSC_TWO_ADDR)) begin
      ssc_two_nxt = strap_two_t'(wdata);
    end
    if (fast_mdix_mode || robust_mdix_mode) begin
      ssc_two_nxt.fast_pd_link_up = 1'b1; // R6
    end
  end

  // control register storage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ssc_two_r <= strap_two_t'(`SSC_TWO_RESET);
    end else begin
      ssc_two_r <= ssc_two_nxt;
    end
  end

  // ----------------------------------------
  // strap latch sequence
  // ----------------------------------------

  // waiting, pulse, running
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_WAIT: begin
        if (config_done) begin
          state_nxt = ST_PULSE; // R2
        end
      end
      ST_PULSE: begin
        if (pulse_cnt_r == `STRAP_RST_CYCLES - 4'h1) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (config_done) begin
          state_nxt = ST_PULSE; // R2
        end
      end
      default: begin
        state_nxt = ST_WAIT;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_WAIT;
    end else begin
      state_r <= state_nxt;
    end
  end

  // pulse length counter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pulse_cnt_r <= 4'h0;
    end else if (state_r == ST_PULSE) begin
      pulse_cnt_r <= pulse_cnt_r + 4'h1;
    end else begin
      pulse_cnt_r <= 4'h0;
    end
  end

  // internal reset pulse, high while pulsing
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      strap_reset_pulse <= 1'b0;
    end else begin
      strap_reset_pulse <= (state_nxt == ST_PULSE); // R2
    end
  end

  // working copy of the strap fields, taken when completion arrives
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      work_r <= strap_two_t'(`SSC_TWO_RESET);
    end else if (config_done && state_r != ST_PULSE) begin
      work_r <= ssc_two_nxt; // R2
    end
  end

  // latched flag for the status read
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      latched_r <= 1'b0;
    end else if (state_r == ST_PULSE) begin
      latched_r <= 1'b1;
    end
  end

  // ----------------------------------------
  // far-end link drop
  // ----------------------------------------

  // remember that a link was up, to spot a loss
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      link_seen_r <= 1'b0;
    end else begin
      link_seen_r <= link_in.link_up;
    end
  end

  // hold the transmitter off for a while after the link is lost
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      drop_active_r <= 1'b0;
      drop_cnt_r <= 16'h0000;
    end else if (!ssc_two_r.forced_fast_remote_link_drop || !link_in.forced_100bt) begin
      drop_active_r <= 1'b0; // R4
      drop_cnt_r <= 16'h0000;
    end else if (link_seen_r && !link_in.link_up) begin
      drop_active_r <= 1'b1; // R3
      drop_cnt_r <= DROP_HOLD;
    end else if (drop_active_r) begin
      drop_cnt_r <= drop_cnt_r - 16'h0001;
      drop_active_r <= (drop_cnt_r != 16'h0001);
    end
  end

  // ----------------------------------------
  // duplex resolution
  // ----------------------------------------

  // extended full duplex overrides the standard outcome
  always_comb begin
    full_duplex_c = link_in.std_full_duplex; // R8
    if (work_r.extended_full_duplex_enable && link_in.partner_forced_100tx &&
        link_in.speed_100 && (link_in.autoneg_on || link_in.forced_100bt)) begin
      full_duplex_c = 1'b1; // R7
    end
  end

  // ----------------------------------------
  // resolved controls
  // ----------------------------------------

  // resolved duplex
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      full_duplex_r <= 1'b0;
    end else begin
      full_duplex_r <= full_duplex_c; // R7 R8
    end
  end

  // link indicator, limited to 100 full duplex when qualified
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      link_led_r <= 1'b0;
    end else begin
      link_led_r <= work_r.qualified_link_led ?
        (link_100(link_in) && full_duplex_c) : link_in.link_up; // R9
    end
  end

  // output isolation on a 100 half duplex link
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mii_isolate_r <= 1'b0;
    end else begin
      mii_isolate_r <= work_r.half_duplex_output_isolation &&
        link_100(link_in) && !full_duplex_c; // R10
    end
  end

  // transmitter off while the far-end drop holds
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_disable_r <= 1'b0;
    end else begin
      tx_disable_r <= drop_active_r; // R3
    end
  end

  // fast link-up select for parallel detection
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fast_pd_r <= 1'b0;
    end else begin
      fast_pd_r <= work_r.fast_pd_link_up; // R5
    end
  end

  // receive data reference select
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rmii_rx_clk_sel_r <= 1'b0;
    end else begin
      rmii_rx_clk_sel_r <= work_r.rmii_rx_clk_ref; // R14
    end
  end

  // control word, every field straight from its flop
  assign ctrl = '{
    full_duplex: full_duplex_r,
    link_led: link_led_r,
    mii_isolate: mii_isolate_r,
    tx_disable: tx_disable_r,
    fast_pd: fast_pd_r,
    rmii_rx_clk_sel: rmii_rx_clk_sel_r
  };

  // ----------------------------------------
  // receive error during idle
  // ----------------------------------------

  // errors inside a frame always pass, idle ones only when enabled
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_err_out <= 1'b0;
    end else begin
      rx_err_out <= rx_sym_err && (!rx_idle || work_r.idle_symbol_error_detect); // R11
    end
  end

  // ----------------------------------------
  // transmit odd nibble check
  // ----------------------------------------

  tx_odd_nibble_guard u_guard (
    .clk(clk),
    .rst(rst),
    .nib_stb(tx_nib_stb),
    .odd_disable(work_r.odd_nibble_disable), // R12
    .tx_en_in(tx_en_in),
    .tx_er_in(tx_er_in),
    .tx_en_out(tx_en_out),
    .tx_er_out(tx_er_out),
    .odd_err(tx_odd_err)
  );

  // ----------------------------------------
  // register read path
  // ----------------------------------------

  // read mux, unmapped addresses read zero
  always_comb begin
    rdata_nxt = '0;
    if (rd && hit(addr, `SSC_TWO_ADDR)) begin
      rdata_nxt = ssc_two_r; // R15
    end else if (rd && hit(addr, `STRAP_STAT_ADDR)) begin
      rdata_nxt = {8'h00, state_r, latched_r, ctrl.full_duplex, ctrl.link_led,
                   ctrl.mii_isolate, ctrl.tx_disable, work_r.fast_pd_link_up};
    end
  end

  // read data stands in the cycle after the strobe only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= '0;
    end else begin
      rdata <= rdata_nxt;
    end
  end

endmodule : phy_soft_strap_config_two

// ### hdl/phy_strap_cfg.svh
// Functional notes
// R1 - software writes the strap fields after reset, then sets bit 15 of the first strap register at 0x0009.
// R2 - on configuration completion an internal reset pulse is made and the strap fields are latched.
// R3 - bit 15 set enables far-end link drop: the transmitter is shut off when the link is lost.
// R4 - far-end link drop acts only in forced 100BT mode and has no effect in any other mode.
// R5 - bit 6 selects fast link-up during parallel detection, clear selects normal timing.
// R6 - bit 6 is set by hardware whenever fast or robust automatic crossover is selected.
// R7 - bit 5 set forces full duplex when in auto-negotiation or forced 100B-TX against a forced 100B-TX partner.
// R8 - bit 5 clear leaves the duplex choice to the standard resolution with no forcing.
// R9 - bit 4 set lights the link indicator only for a 100B-TX full duplex link, clear for any link.
// R10 - bit 3 set isolates the MII outputs while an established 100B-TX link is half duplex.
// R11 - bit 2 enables or disables reporting of receive symbol errors seen during idle.
// R12 - bit 1 set suppresses the transmit error on a TX_EN drop at an odd nibble.
// R13 - with detection on, a TX_EN drop at an odd nibble extends TX_EN one nibble with TX_ER high.
// R14 - bit 0 picks the RMII receive data reference: one RX_CLK, zero the crystal clock input.
// R15 - software keeps reserved bits 14 and 13:7 by read-modify-write when writing this register.
`ifndef PHY_STRAP_CFG_SVH
`define PHY_STRAP_CFG_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define ADDR_W 5
`define DATA_W 16
`define SSC_TWO_ADDR 5'h0A
`define STRAP_STAT_ADDR 5'h1A
`define SSC_TWO_RESET 16'h0100

// ----------------------------------------
// field positions
// ----------------------------------------
`define B_FAR_DROP 15
`define B_FAST_PD 6
`define B_EXT_FD 5
`define B_QUAL_LED 4
`define B_HD_ISO 3
`define B_IDLE_ERR 2
`define B_ODD_DIS 1
`define B_RMII_RXCLK 0

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_MHZ 100
`define STRAP_RST_CYCLES 4'h4
`define FAR_DROP_HOLD_US 20
`define FAR_DROP_HOLD_CYC (`FAR_DROP_HOLD_US * `CLK_MHZ)

`endif

// ### hdl/phy_strap_pkg.sv
package phy_strap_pkg;

  // ----------------------------------------
  // register layout
  // ----------------------------------------
  typedef struct packed {
    logic forced_fast_remote_link_drop;
    logic rsvd_14;
    logic [6:0] rsvd_13_7;
    logic fast_pd_link_up;
    logic extended_full_duplex_enable;
    logic qualified_link_led;
    logic half_duplex_output_isolation;
    logic idle_symbol_error_detect;
    logic odd_nibble_disable;
    logic rmii_rx_clk_ref;
  } strap_two_t;

  // link state from the pcs and auto-negotiation logic
  typedef struct packed {
    logic link_up;
    logic speed_100;
    logic forced_100bt;
    logic autoneg_on;
    logic partner_forced_100tx;
    logic std_full_duplex;
  } link_state_t;

  // resolved controls toward the datapath
  typedef struct packed {
    logic full_duplex;
    logic link_led;
    logic mii_isolate;
    logic tx_disable;
    logic fast_pd;
    logic rmii_rx_clk_sel;
  } link_ctrl_t;

  // strap latch sequencer
  typedef enum logic [1:0] {
    ST_WAIT = 2'b00,
    ST_PULSE = 2'b01,
    ST_RUN = 2'b11
  } strap_state_t;

endpackage : phy_strap_pkg

// ### hdl/tx_odd_nibble_guard.sv
`include "phy_strap_cfg.svh"

module tx_odd_nibble_guard
  import phy_strap_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic nib_stb,
  input wire logic odd_disable,
  input wire logic tx_en_in,
  input wire logic tx_er_in,
  output logic tx_en_out,
  output logic tx_er_out,
  output logic odd_err
);

  logic odd_r;
  logic ext_r;

  // frame end after an odd count of nibbles, while detection is on
  function automatic logic odd_end(input logic en, input logic odd, input logic ext, input logic dis);
    odd_end = !en && odd && !ext && !dis;
  endfunction : odd_end

  // ----------------------------------------
  // nibble parity within the frame
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      odd_r <= 1'b0;
    end else if (nib_stb) begin
      odd_r <= tx_en_in ? ~odd_r : 1'b0;
    end
  end

  // ----------------------------------------
  // one extra nibble with error on an odd end
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ext_r <= 1'b0;
    end else if (nib_stb) begin
      ext_r <= odd_end(tx_en_in, odd_r, ext_r, odd_disable); // R12 R13
    end
  end

  // passed-through nibble state, updated per nibble
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_en_out <= 1'b0;
      tx_er_out <= 1'b0;
    end else if (nib_stb) begin
      tx_en_out <= tx_en_in | odd_end(tx_en_in, odd_r, ext_r, odd_disable); // R13
      tx_er_out <= tx_er_in | odd_end(tx_en_in, odd_r, ext_r, odd_disable); // R13
    end
  end

  // error event, one cycle at the start of the extension
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      odd_err <= 1'b0;
    end else begin
      odd_err <= nib_stb && odd_end(tx_en_in, odd_r, ext_r, odd_disable); // R13
    end
  end

endmodule : tx_odd_nibble_guard

// ### dv/strap_props.sv
module strap_props
  import phy_strap_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic config_done,
  input wire link_state_t link_in,
  input wire logic rx_sym_err,
  input wire logic tx_nib_stb,
  input wire logic tx_en_in,
  input wire logic strap_reset_pulse,
  input wire link_ctrl_t ctrl,
  input wire logic rx_err_out,
  input wire logic tx_en_out,
  input wire logic tx_er_out,
  input wire logic tx_odd_err
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // pulse steps: high four cycles, then low
  sequence s_pulse_high;
    strap_reset_pulse [*4];
  endsequence
  sequence s_pulse_end;
    !strap_reset_pulse;
  endsequence

  property p_pulse_len;
    $rose(strap_reset_pulse) |-> s_pulse_high ##1 s_pulse_end;
  endproperty
  property p_pulse_cause;
    $rose(strap_reset_pulse) |-> $past(config_done);
  endproperty
  property p_led;
    ctrl.link_led |-> $past(link_in.link_up);
  endproperty
  property p_iso;
    ctrl.mii_isolate |-> !ctrl.full_duplex && $past(link_in.link_up && link_in.speed_100);
  endproperty
  property p_full;
    ctrl.full_duplex && !$past(link_in.std_full_duplex) |-> $past(link_in.partner_forced_100tx && link_in.speed_100);
  endproperty
  property p_drop;
    ctrl.tx_disable |-> $past(link_in.forced_100bt, 2);
  endproperty
  property p_rx_err;
    rx_err_out |-> $past(rx_sym_err);
  endproperty
  property p_odd_flag;
    tx_odd_err |-> tx_en_out && tx_er_out;
  endproperty
  property p_odd_cause;
    tx_odd_err |-> $past(tx_nib_stb && !tx_en_in);
  endproperty
  property p_odd_once;
    tx_odd_err |=> !tx_odd_err;
  endproperty

  a_pulse_len: assert property (p_pulse_len) else $error("strap pulse length wrong");
  a_pulse_cause: assert property (p_pulse_cause) else $error("strap pulse without completion");
  a_led: assert property (p_led) else $error("link led without link");
  a_iso: assert property (p_iso) else $error("isolation outside 100 half duplex");
  a_full: assert property (p_full) else $error("full duplex forced wrongly");
  a_drop: assert property (p_drop) else $error("tx disable outside forced mode");
  a_rx_err: assert property (p_rx_err) else $error("receive error without cause");
  a_odd_flag: assert property (p_odd_flag) else $error("odd extension not marked");
  a_odd_cause: assert property (p_odd_cause) else $error("odd error without frame end");
  a_odd_once: assert property (p_odd_once) else $error("odd error longer than one cycle");
endmodule : strap_props

bind phy_soft_strap_config_two strap_props u_props (
  .clk(clk), .rst(rst), .config_done(config_done), .link_in(link_in), .rx_sym_err(rx_sym_err),
  .tx_nib_stb(tx_nib_stb), .tx_en_in(tx_en_in), .strap_reset_pulse(strap_reset_pulse), .ctrl(ctrl),
  .rx_err_out(rx_err_out), .tx_en_out(tx_en_out), .tx_er_out(tx_er_out), .tx_odd_err(tx_odd_err)
);

// ### dv/tb.sv
`include "phy_strap_cfg.svh"

module tb
  import phy_strap_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, wr, rd, config_done, fast_mdix_mode, robust_mdix_mode;
  logic rx_sym_err, rx_idle, tx_nib_stb, tx_en_in, tx_er_in;
  logic strap_reset_pulse, rx_err_out, tx_en_out, tx_er_out, tx_odd_err;
  logic [`ADDR_W-1:0] addr;
  logic [`DATA_W-1:0] wdata, rdata;
  link_state_t link_in;
  link_ctrl_t ctrl;
  int failures, check_count, cycles;

  phy_soft_strap_config_two dut (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .config_done(config_done), .fast_mdix_mode(fast_mdix_mode), .robust_mdix_mode(robust_mdix_mode),
    .link_in(link_in), .rx_sym_err(rx_sym_err), .rx_idle(rx_idle), .tx_nib_stb(tx_nib_stb),
    .tx_en_in(tx_en_in), .tx_er_in(tx_er_in), .strap_reset_pulse(strap_reset_pulse), .ctrl(ctrl),
    .rx_err_out(rx_err_out), .tx_en_out(tx_en_out), .tx_er_out(tx_er_out), .tx_odd_err(tx_odd_err)
  );

  // ----
  // tasks
  // ----
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [4:0] a, input logic [15:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk("rdata", exp, rdata);
    @(posedge clk);
    #1 chk("rdata idle", 16'h0000, rdata);
  endtask : rd_reg

  // completion pulse, then internal pulse high four cycles
  task automatic latch();
    @(posedge clk);
    config_done <= 1'b1;
    @(posedge clk);
    config_done <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      #1 chk("pulse", 16'(i < 4), 16'(strap_reset_pulse));
      if (i < 4) @(posedge clk);
    end
  endtask : latch

  task automatic link(input link_state_t ls, input logic [5:0] exp, input int n);
    @(posedge clk);
    link_in <= ls;
    repeat (n) @(posedge clk);
    #1 chk("ctrl", {10'h000, exp}, {10'h000, ctrl});
  endtask : link

  task automatic rxe(input logic idle, input logic exp);
    @(posedge clk);
    rx_idle <= idle;
    rx_sym_err <= 1'b1;
    @(posedge clk);
    rx_sym_err <= 1'b0;
    #1 chk("rx_err", 16'(exp), 16'(rx_err_out));
  endtask : rxe

  task automatic nib(input logic en, input logic [2:0] exp);
    @(posedge clk);
    tx_nib_stb <= 1'b1;
    tx_en_in <= en;
    @(posedge clk);
    tx_nib_stb <= 1'b0;
    #1 chk("tx", {13'h0000, exp}, {13'h0000, tx_en_out, tx_er_out, tx_odd_err});
  endtask : nib

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test

  // ----
  // clock, timeout, tests
  // ----
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      end_of_test();
    end
  end

  initial begin
    {rst, wr, rd, config_done, fast_mdix_mode, robust_mdix_mode} = 6'h3F & 6'h20;
    {rx_sym_err, tx_nib_stb, tx_en_in, tx_er_in} = 4'h0;
    rx_idle = 1'b1;
    addr = '0;
    wdata = '0;
    link_in = '0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd_reg(5'h0A, 16'h0100);
    wr_reg(5'h05, 16'hFFFF);
    rd_reg(5'h05, 16'h0000);
    wr_reg(5'h0A, 16'h013D);
    rd_reg(5'h0A, 16'h013D);
    latch();
    rd_reg(5'h1A, 16'h00E0);
    $display("test register and latch done");
    link(6'b110110, 6'b110001, 1);
    rxe(1'b1, 1'b1);
    wr_reg(5'h0A, 16'h0108);
    latch();
    link(6'b110110, 6'b011000, 1);
    rxe(1'b1, 1'b0);
    rxe(1'b0, 1'b1);
    $display("test fields done");
    for (int m = 0; m < 2; m++) begin
      @(posedge clk);
      fast_mdix_mode <= (m == 0);
      robust_mdix_mode <= (m == 1);
      wr_reg(5'h0A, 16'h0100);
      rd_reg(5'h0A, 16'h0140);
    end
    @(posedge clk);
    fast_mdix_mode <= 1'b0;
    robust_mdix_mode <= 1'b0;
    latch();
    link(6'b000000, 6'b000010, 1);
    wr_reg(5'h0A, 16'h0100);
    latch();
    link(6'b000000, 6'b000000, 1);
    $display("test parallel detect done");
    for (int k = 0; k < 2; k++) begin
      repeat (3) nib(1'b1, 3'b100);
      nib(1'b0, k ? 3'b000 : 3'b111);
      nib(1'b0, 3'b000);
      wr_reg(5'h0A, 16'h0102);
      latch();
    end
    $display("test odd nibble done");
    wr_reg(5'h0A, 16'h8102);
    link(6'b111000, 6'b010000, 1);
    link(6'b011000, 6'b000100, 3);
    wr_reg(5'h0A, 16'h0102);
    link(6'b011000, 6'b000000, 1);
    wr_reg(5'h0A, 16'h8102);
    link(6'b110000, 6'b010000, 1);
    link(6'b010000, 6'b000000, 3);
    link(6'b111000, 6'b010000, 1);
    link(6'b011000, 6'b000100, `FAR_DROP_HOLD_CYC + 1);
    link(6'b011000, 6'b000000, 1);
    $display("test far end drop done");
    end_of_test();
  end
endmodule : tb
